// File: rtl/dcf_cfg.svh
// constants for the fifo flag block: sizes, offsets, defaults and timing
`ifndef DCF_CFG_SVH
`define DCF_CFG_SVH
`define DCF_DATA_W 18
`define DCF_ADDR_W 13
`define DCF_PTR_W 14
`define DCF_OFS_W 13
`define DCF_MEM_WORDS 8192
`define DCF_DEPTH 14'h2000
`define DCF_HALF 14'h1000
`define DCF_PTR_ZERO 14'h0000
`define DCF_WORD_ZERO 18'h00000
`define DCF_OFS_DEFAULT 13'h007f
`define DCF_CLK_PERIOD_NS 4
`define DCF_RETX_NS 60
`define DCF_RETX_CYCLES ((`DCF_RETX_NS + `DCF_CLK_PERIOD_NS - 1) / `DCF_CLK_PERIOD_NS)
`define DCF_RETX_CNT_W 4
`define DCF_RETX_CNT_ZERO 4'h0
`define DCF_AXI_ADDR_W 8
`define DCF_REG_CTRL 8'h00
`define DCF_REG_AE_OFS 8'h04
`define DCF_REG_AF_OFS 8'h08
`define DCF_REG_STATUS 8'h0c
`define DCF_CTRL_MODE_BIT 0
`define DCF_CTRL_RETX_BIT 1
`define DCF_RESP_OKAY 2'h0
`define DCF_RESP_SLVERR 2'h2
`endif

// File: rtl/dcf_pkg.sv
// types shared by the fifo flag block
`include "dcf_cfg.svh"
package dcf_pkg;
  typedef logic [`DCF_DATA_W-1:0] dcf_word_t;
  typedef logic [`DCF_PTR_W-1:0] dcf_ptr_t;
  typedef logic [`DCF_RETX_CNT_W-1:0] dcf_retx_cnt_t;
  typedef enum logic [0:0] {
    DCF_RETX_IDLE = 1'b0,
    DCF_RETX_WAIT = 1'b1
  } dcf_retx_state_t;
endpackage

// File: rtl/dcf_mem.sv
// word store with a registered read port
`timescale 1ns/1ps
`include "dcf_cfg.svh"
module dcf_mem (
  input wire logic clk,
  input wire logic rstN,
  input wire logic clkEn,
  input wire logic wrEn,
  input wire logic [`DCF_ADDR_W-1:0] wrAddr,
  input wire dcf_pkg::dcf_word_t wrData,
  input wire logic rdEn,
  input wire logic [`DCF_ADDR_W-1:0] rdAddr,
  output var dcf_pkg::dcf_word_t rdData
);
  import dcf_pkg::*;
  dcf_word_t store [0:`DCF_MEM_WORDS-1];
  always_ff @(posedge clk) begin
    if (clkEn && wrEn) begin
      store[wrAddr] <= wrData;
    end
  end
  // read data only moves on a read, so it doubles as the output register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rdData <= `DCF_WORD_ZERO;
    end else if (clkEn && rdEn) begin
      rdData <= store[rdAddr];
    end
  end
endmodule // dcf_mem

// File: rtl/dcf_ptr_delay.sv
// one register stage that carries a pointer to the opposite flag side
`timescale 1ns/1ps
`include "dcf_cfg.svh"
module dcf_ptr_delay (
  input wire logic clk,
  input wire logic rstN,
  input wire logic clkEn,
  input wire logic clear,
  input wire dcf_pkg::dcf_ptr_t ptrIn,
  output var dcf_pkg::dcf_ptr_t ptrOut
);
  import dcf_pkg::*;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ptrOut <= `DCF_PTR_ZERO;
    end else if (clkEn) begin
      ptrOut <= clear ? `DCF_PTR_ZERO : ptrIn;
    end
  end
endmodule // dcf_ptr_delay

// File: rtl/dcf_top.sv
// fifo with status flags, fall-through mode, retransmit and register slave
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "dcf_cfg.svh"

module dcf_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic masterResetN,
  input wire logic partialResetN,
  input wire logic writeEnableN,
  input wire dcf_pkg::dcf_word_t dataIn,
  input wire logic readEnableN,
  output wire dcf_pkg::dcf_word_t dataOutBus,
  output wire logic fullFlagN,
  output wire logic emptyFlagN,
  output wire logic halfFullFlagN,
  output wire logic almostEmptyFlagN,
  output wire logic almostFullFlagN,
  input wire logic [`DCF_AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output wire logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`DCF_AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output wire logic s_axi_arready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import dcf_pkg::*;

  logic [1:0] rstSync_reg;
  logic rstN;
  logic modeReq_reg, mode_reg;
  logic [`DCF_OFS_W-1:0] aeOfs_reg, afOfs_reg;
  dcf_ptr_t wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  dcf_ptr_t wrPtrSync, rdPtrSync, cntAfter, wrSideCount, rdSideCount, liveCount;
  logic full_reg, empty_reg, outValid_reg, hfLow_reg, ae_reg, af_reg;
  logic fullNext, emptyNext, outValidNext, hfLowNext, aeNext, afNext;
  dcf_retx_state_t retxState_reg, retxState_next;
  dcf_retx_cnt_t retxCnt_reg, retxCnt_next;
  logic awHeld_reg, wHeld_reg, retxReq;
  logic [`DCF_AXI_ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg, wMask, ctrlWord, statusWord, rdMux;
  logic [3:0] wStrb_reg;

  // reset release through two stages
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_reg <= 2'h0;
    end else if (clkEn) begin
      rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
  end
  assign rstN = rstSync_reg[1];

  wire ptrClear = !masterResetN || !partialResetN;
  wire retxBusy = retxState_reg == DCF_RETX_WAIT;
  wire retxDone = retxBusy && (retxCnt_reg == `DCF_RETX_CNT_ZERO);

  wire wrDo = !writeEnableN && !full_reg && !ptrClear;
  wire stdRead = !mode_reg && !readEnableN && !empty_reg && !retxBusy;
  // word seen one stage after write
  wire memAvail = (wrPtrSync != rdPtr_reg) && !retxBusy;
  wire readTaken = mode_reg && !readEnableN && outValid_reg;
  wire prefetch = mode_reg && memAvail && (!outValid_reg || readTaken);
  wire memRd = !ptrClear && (mode_reg ? prefetch : stdRead);

  assign wrPtr_next = ptrClear ? `DCF_PTR_ZERO : wrPtr_reg + dcf_ptr_t'(wrDo);
  assign rdPtr_next = (ptrClear || retxDone) ? `DCF_PTR_ZERO : rdPtr_reg + dcf_ptr_t'(memRd);
  assign cntAfter = wrPtr_next - rdPtr_next;
  assign wrSideCount = wrPtr_next - rdPtrSync;
  assign rdSideCount = wrPtrSync - rdPtr_next;
  assign liveCount = wrPtr_reg - rdPtr_reg;

  dcf_ptr_delay u_wrPtrCross (
    .clk(sys_clk),
    .rstN(rstN),
    .clkEn(clkEn),
    .clear(ptrClear),
    .ptrIn(wrPtr_reg),
    .ptrOut(wrPtrSync)
  );
  dcf_ptr_delay u_rdPtrCross (
    .clk(sys_clk),
    .rstN(rstN),
    .clkEn(clkEn),
    .clear(ptrClear),
    .ptrIn(rdPtr_reg),
    .ptrOut(rdPtrSync)
  );
  dcf_mem u_mem (
    .clk(sys_clk),
    .rstN(rstN),
    .clkEn(clkEn),
    .wrEn(wrDo),
    .wrAddr(wrPtr_reg[`DCF_ADDR_W-1:0]),
    .wrData(dataIn),
    .rdEn(memRd),
    .rdAddr(rdPtr_reg[`DCF_ADDR_W-1:0]),
    .rdData(dataOutBus)
  );

  // counts measured on memory words only; the fall-through output word
  // shifts every threshold by one, which gives the larger fall-through depth
  // full follows delayed read pointer
  assign fullNext = !ptrClear && (wrSideCount == `DCF_DEPTH);
  assign emptyNext = ptrClear || retxBusy || retxReq || (rdSideCount == `DCF_PTR_ZERO);
  // output word dropped on last read
  assign outValidNext = !ptrClear && !retxBusy && !retxReq
                        && (prefetch || (outValid_reg && !readTaken));
  // set by writes, cleared by reads
  wire hfSet = wrDo && (cntAfter > `DCF_HALF);
  wire hfClr = memRd && (cntAfter <= `DCF_HALF);
  assign hfLowNext = !ptrClear && (hfSet || (hfLow_reg && !hfClr));
  assign aeNext = ptrClear || retxBusy || (rdSideCount <= {1'b0, aeOfs_reg});
  assign afNext = !ptrClear && (wrSideCount >= (`DCF_DEPTH - {1'b0, afOfs_reg}));

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_reg <= `DCF_PTR_ZERO;
      rdPtr_reg <= `DCF_PTR_ZERO;
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
      outValid_reg <= 1'b0;
      hfLow_reg <= 1'b0;
      ae_reg <= 1'b1;
      af_reg <= 1'b0;
    end else if (clkEn) begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      full_reg <= fullNext;
      empty_reg <= emptyNext;
      outValid_reg <= outValidNext;
      hfLow_reg <= hfLowNext;
      ae_reg <= aeNext;
      af_reg <= afNext;
    end
  end

  assign fullFlagN = mode_reg ? full_reg : !full_reg;
  assign emptyFlagN = mode_reg ? !outValid_reg : !empty_reg;
  // half-full pin from the set/clear state
  assign halfFullFlagN = !hfLow_reg;
  assign almostEmptyFlagN = !ae_reg;
  assign almostFullFlagN = !af_reg;

  // retransmit setup timer
  always_comb begin
    retxState_next = retxState_reg;
    retxCnt_next = retxCnt_reg;
    unique case (retxState_reg)
      DCF_RETX_IDLE: begin
        if (retxReq) begin
          retxState_next = DCF_RETX_WAIT;
          retxCnt_next = dcf_retx_cnt_t'(`DCF_RETX_CYCLES - 1);
        end
      end
      DCF_RETX_WAIT: begin
        if (retxCnt_reg == `DCF_RETX_CNT_ZERO) begin
          retxState_next = DCF_RETX_IDLE;
        end else begin
          retxCnt_next = retxCnt_reg - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      retxState_reg <= DCF_RETX_IDLE;
      retxCnt_reg <= `DCF_RETX_CNT_ZERO;
    end else if (clkEn) begin
      retxState_reg <= ptrClear ? DCF_RETX_IDLE : retxState_next;
      retxCnt_reg <= retxCnt_next;
    end
  end

  // register slave; address and data may arrive in either order
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_strb
      assign wMask[gi*8 +: 8] = {8{wStrb_reg[gi]}};
    end
  endgenerate

  assign s_axi_awready = !awHeld_reg;
  assign s_axi_wready = !wHeld_reg;
  assign s_axi_arready = !s_axi_rvalid;
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire regWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  wire awCtrl = awAddr_reg == `DCF_REG_CTRL;
  wire awAe = awAddr_reg == `DCF_REG_AE_OFS;
  wire awAf = awAddr_reg == `DCF_REG_AF_OFS;
  wire awHit = awCtrl || awAe || awAf || (awAddr_reg == `DCF_REG_STATUS);
  wire modeWrite = regWrite && awCtrl && wMask[`DCF_CTRL_MODE_BIT];
  assign retxReq = regWrite && awCtrl && wMask[`DCF_CTRL_RETX_BIT]
                   && wData_reg[`DCF_CTRL_RETX_BIT] && !retxBusy;
  wire [31:0] aeMerged = ({19'h0, aeOfs_reg} & ~wMask) | (wData_reg & wMask);
  wire [31:0] afMerged = ({19'h0, afOfs_reg} & ~wMask) | (wData_reg & wMask);

  wire arCtrl = s_axi_araddr == `DCF_REG_CTRL;
  wire arAe = s_axi_araddr == `DCF_REG_AE_OFS;
  wire arAf = s_axi_araddr == `DCF_REG_AF_OFS;
  wire arSt = s_axi_araddr == `DCF_REG_STATUS;
  assign ctrlWord = {31'h0, modeReq_reg};
  assign statusWord = {2'h0, liveCount, 9'h0, retxBusy, mode_reg, af_reg, ae_reg,
                       hfLow_reg, fullFlagN, emptyFlagN};
  assign rdMux = arCtrl ? ctrlWord : arAe ? {19'h0, aeOfs_reg} :
                 arAf ? {19'h0, afOfs_reg} : arSt ? statusWord : 32'h0;

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DCF_RESP_OKAY;
    end else if (clkEn) begin
      if (awTake) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end else if (regWrite) begin
        awHeld_reg <= 1'b0;
      end
      if (wTake) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end else if (regWrite) begin
        wHeld_reg <= 1'b0;
      end
      if (regWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= awHit ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `DCF_RESP_OKAY;
    end else if (clkEn) begin
      if (arTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= (arCtrl || arAe || arAf || arSt) ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // requested mode and offset defaults taken at master reset
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      modeReq_reg <= 1'b0;
      mode_reg <= 1'b0;
      aeOfs_reg <= `DCF_OFS_DEFAULT;
      afOfs_reg <= `DCF_OFS_DEFAULT;
    end else if (clkEn) begin
      if (modeWrite) begin
        modeReq_reg <= wData_reg[`DCF_CTRL_MODE_BIT];
      end
      if (!masterResetN) begin
        mode_reg <= modeReq_reg;
        aeOfs_reg <= `DCF_OFS_DEFAULT;
        afOfs_reg <= `DCF_OFS_DEFAULT;
      end else begin
        if (regWrite && awAe) begin
          aeOfs_reg <= aeMerged[`DCF_OFS_W-1:0];
        end
        if (regWrite && awAf) begin
          afOfs_reg <= afMerged[`DCF_OFS_W-1:0];
        end
      end
    end
  end

  // checks assume clkEn held high; a frozen cycle stretches every window
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstN || !clkEn || ptrClear);
  localparam int flagLag = 3;
  localparam int retxLen = `DCF_RETX_CYCLES;

  a_hf_set_write: assert property (
    wrDo && (cntAfter > `DCF_HALF) |=> !halfFullFlagN)
    else $error("half-full stayed high after filling write");
  a_hf_clear_read: assert property (
    memRd && !wrDo && (cntAfter <= `DCF_HALF) && !halfFullFlagN |=> halfFullFlagN)
    else $error("half-full stayed low after read");
  a_hf_std_count: assert property (
    !mode_reg && (liveCount == `DCF_HALF) && wrDo && !memRd
    |=> !halfFullFlagN)
    else $error("half-full not low after half depth plus one writes");
  a_full_gate: assert property (
    !mode_reg && !fullFlagN && !writeEnableN |=> $stable(wrPtr_reg))
    else $error("write accepted while full");
  a_full_release: assert property (
    full_reg && memRd |-> ##[1:flagLag] !full_reg)
    else $error("full flag not released after read");
  a_empty_release: assert property (
    !mode_reg && empty_reg && wrDo && !retxBusy && !retxReq |-> ##[1:flagLag] emptyFlagN)
    else $error("empty flag not released after write");
  a_or_fall: assert property (
    mode_reg && !outValid_reg && (wrPtr_reg == rdPtr_reg) && wrDo && !retxBusy && !retxReq
    |-> ##[1:flagLag] !emptyFlagN)
    else $error("output-ready late after first write");
  a_or_last_read: assert property (
    readTaken && !prefetch |=> emptyFlagN)
    else $error("output-ready held after last word read");
  a_retx_span: assert property (
    $rose(retxBusy) |-> ##[retxLen:retxLen] !retxBusy)
    else $error("retransmit setup length wrong");
  a_retx_block: assert property (
    retxBusy |-> !memRd && (mode_reg ? emptyFlagN : !emptyFlagN))
    else $error("read side active during retransmit setup");

  c_hf_set: cover property (wrDo ##1 !halfFullFlagN);
  c_full_hit: cover property (!mode_reg && $fell(fullFlagN));
  c_fall_through_mode_out: cover property (mode_reg && $fell(emptyFlagN) ##[1:8] readTaken);
  c_retx_run: cover property ($fell(retxBusy));
endmodule // dcf_top

// File: bench/dcf_stream_partner.sv
// writer and reader controllers that sit on the far side of the fifo
`timescale 1ns/1ps
module dcf_stream_partner (
  input wire logic sys_clk,
  input wire logic wrOn,
  input wire logic rdOn,
  input wire logic [1:0] stall,
  input wire dcf_pkg::dcf_word_t wrWord,
  input wire logic fallThrough,
  input wire logic emptyFlagN,
  output var logic writeEnableN,
  output var dcf_pkg::dcf_word_t dataIn,
  output var logic readEnableN
);
  import dcf_pkg::*;
  initial begin
    writeEnableN = 1'b1;
    readEnableN = 1'b1;
    dataIn = 18'h00000;
  end
  // writer, reader and transfer share sys_clk
  // no space check on the write side, so the fifo itself has to refuse
  always @(posedge sys_clk) begin
    writeEnableN <= !(wrOn && !stall[0]);
    dataIn <= wrWord;
  end
  // read only while a word was offered at the previous edge, so at most in the first setup cycle
  always @(posedge sys_clk) begin
    readEnableN <= !(rdOn && !stall[1] && (fallThrough ? !emptyFlagN : emptyFlagN));
  end
endmodule // dcf_stream_partner

// File: bench/test_dcf_top.sv
// self-checking bench for the fifo flag block against a queue model
`timescale 1ns/1ps
module test_dcf_top;
  import dcf_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, mrN = 1'b1, prN = 1'b1, wrOn = 1'b0, rdOn = 1'b0;
  logic ft = 1'b0, chk = 1'b0, stallEn = 1'b0, pend = 1'b0;
  logic [1:0] stall = 2'h0;
  logic [31:0] rnd = 32'h5570;
  dcf_word_t wrWord = 18'h00000, dataIn, dataOutBus, pendWord;
  logic weN, reN, ffN, efN, hfN, aeN, afN;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  int miscompares = 0, cmp_count = 0, cycles = 0, rdIdx = 0, qW = 9, qR = 9, n;
  int lastWr, lastRd, lastAxi, aeOfs = 127, afOfs = 127;
  dcf_word_t hist[$];

  dcf_top i_dcf_top (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(1'b1), .masterResetN(mrN),
    .partialResetN(prN), .writeEnableN(weN), .dataIn(dataIn), .readEnableN(reN),
    .dataOutBus(dataOutBus), .fullFlagN(ffN), .emptyFlagN(efN), .halfFullFlagN(hfN),
    .almostEmptyFlagN(aeN), .almostFullFlagN(afN), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  dcf_stream_partner i_dcf_stream_partner (.sys_clk(sys_clk), .wrOn(wrOn), .rdOn(rdOn),
    .stall(stall), .wrWord(wrWord), .fallThrough(ft), .emptyFlagN(efN),
    .writeEnableN(weN), .dataIn(dataIn), .readEnableN(reN));

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] act);
    cmp_count++;
    if (exp !== act) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, act);
    end
  endtask

  task automatic give_verdict;
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // random stalls and data; the ceiling is about three times the planned run
  always @(posedge sys_clk) begin
    rnd <= xs(rnd);
    wrWord <= rnd[17:0];
    stall <= rnd[21:20] & {2{stallEn}};
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      give_verdict;
    end
  end

  // queue model: every accepted write is kept, so retransmit just rewinds
  always @(posedge sys_clk) begin
    qW <= qW + 1;
    qR <= qR + 1;
    if (!rst_n || !mrN || !prN) begin
      hist.delete();
      rdIdx = 0;
    end else begin
      // one device, its own flags are the composite
      if (!weN && (ft ? !ffN : ffN)) begin
        hist.push_back(dataIn);
        qW <= 0;
        lastWr = cycles;
      end
      if (!reN && ft && !efN) begin
        cmp("fall_through_mode word", hist[rdIdx], dataOutBus);
        rdIdx++;
        qR <= 0;
        lastRd = cycles;
      end
      if (!reN && !ft && efN) begin
        pendWord = hist[rdIdx];
        pend = 1'b1;
        rdIdx++;
        qR <= 0;
        lastRd = cycles;
      end
    end
  end

  // flags are exact once the opposite side has been quiet for two edges
  always @(negedge sys_clk) begin
    if (pend)
      cmp("std word", pendWord, dataOutBus);
    pend = 1'b0;
    if (chk && !ft) begin
      n = hist.size() - rdIdx;
      cmp("half full", n <= 4096, hfN);
      if (qW >= 2) begin
        cmp("empty", n != 0, efN);
        cmp("almost empty", n > aeOfs, aeN);
      end
      if (qR >= 2) begin
        cmp("full", n != 8192, ffN);
        cmp("almost full", n < 8192 - afOfs, afN);
      end
    end
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w;
    aw = 0;
    w = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge sys_clk);
      if (awvalid && awready) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    lastAxi = cycles;
    bready <= 1'b1;
    do @(posedge sys_clk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // edges from the causing edge until the flag shows the wanted level
  task automatic lat(input bit full, input logic want, input int from, input int mn,
                     input int mx);
    int k;
    k = 0;
    while ((full ? ffN : efN) !== want && k < 40) begin
      @(negedge sys_clk);
      k++;
    end
    k = cycles - from - 1;
    cmp("latency in range", 1'b1, k >= mn && k <= mx);
  endtask

  // a single write or read with no stalls, ending just after its edge
  task automatic one(input bit w);
    if (w) wrOn <= 1'b1;
    else rdOn <= 1'b1;
    @(posedge sys_clk);
    wrOn <= 1'b0;
    rdOn <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic run(input bit w, input bit r, input int cnt);
    @(posedge sys_clk);
    wrOn <= w;
    rdOn <= r;
    repeat (cnt) @(posedge sys_clk);
    wrOn <= 1'b0;
    rdOn <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic mreset(input bit f);
    axi_wr(8'h00, {31'h0, f});
    mrN <= 1'b0;
    @(posedge sys_clk);
    mrN <= 1'b1;
    ft <= f;
    aeOfs = 127;
    afOfs = 127;
    repeat (3) @(posedge sys_clk);
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    axi_rd(8'h04);
    cmp("ae offset reset", 32'h7f, rd);
    axi_rd(8'h08);
    cmp("af offset reset", 32'h7f, rd);
    axi_rd(8'h10);
    cmp("hole read resp", 2'h2, resp);
    axi_wr(8'h10, 32'h1);
    cmp("hole write resp", 2'h2, resp);
    axi_wr(8'h0c, 32'hffff);
    cmp("status write resp", 2'h0, resp);
    axi_wr(8'h04, 32'h40);
    aeOfs = 64;
    axi_wr(8'h08, 32'h100);
    afOfs = 256;
    chk = 1'b1;
    stallEn = 1'b1;
    run(1, 1, 3000);
    run(0, 1, 600);
    stallEn = 1'b0;
    // let the last random stall drain out of the partner
    repeat (2) @(posedge sys_clk);
    one(1);
    lat(0, 1'b1, lastWr, 1, 2);
    one(0);
    // crossing the half-depth line both ways, then filling past full
    run(1, 0, 4098);
    one(0);
    one(0);
    run(1, 0, 4104);
    one(0);
    lat(1, 1'b1, lastRd, 1, 2);
    chk = 1'b0;
    @(posedge sys_clk);
    prN <= 1'b0;
    @(posedge sys_clk);
    prN <= 1'b1;
    repeat (3) @(posedge sys_clk);
    axi_rd(8'h04);
    cmp("ae offset kept", 32'h40, rd);
    chk = 1'b1;
    // far fewer than depth minus two words before the rewind
    run(1, 0, 10);
    axi_rd(8'h0c);
    cmp("status word", 32'h000a000b, rd);
    run(0, 1, 3);
    chk = 1'b0;
    axi_wr(8'h00, 32'h2);
    rdIdx = 0;
    lat(0, 1'b1, lastAxi + 1, 16, 19);
    repeat (3) @(negedge sys_clk);
    chk = 1'b1;
    run(0, 1, 12);
    cmp("retransmit count", 10, rdIdx);
    chk = 1'b0;
    mreset(1'b1);
    one(1);
    lat(0, 1'b0, lastWr, 2, 3);
    one(0);
    repeat (3) @(negedge sys_clk);
    cmp("output ready idle", 1'b1, efN);
    run(1, 0, 4097);
    cmp("fall_through_mode half below", 1'b1, hfN);
    one(1);
    cmp("fall_through_mode half above", 1'b0, hfN);
    stallEn = 1'b1;
    run(1, 1, 3000);
    give_verdict;
  end
endmodule // test_dcf_top
